/* File: include/ifsb_regs.vh */
`ifndef IFSB_REGS_VH
`define IFSB_REGS_VH

// byte offsets, low address byte only
`define IFSB_A_FLAG0 8'h00
`define IFSB_A_FLAG1 8'h04
`define IFSB_A_FLAG2 8'h08
`define IFSB_A_FLAG3 8'h0c
`define IFSB_A_EN0 8'h10
`define IFSB_A_EN1 8'h14
`define IFSB_A_EN2 8'h18
`define IFSB_A_EN3 8'h1c
`define IFSB_A_CLR0 8'h20
`define IFSB_A_CLR1 8'h24
`define IFSB_A_CLR2 8'h28
`define IFSB_A_CLR3 8'h2c

// implemented bits of each flag / enable register
`define IFSB_IMPL0 16'h3fef
`define IFSB_IMPL1 16'hfe1f
`define IFSB_IMPL2 16'h22e3
`define IFSB_IMPL3 16'h4006

`define IFSB_RST8 8'h00
`define IFSB_RST16 16'h0000
`define IFSB_RST32 32'h0000_0000
`define IFSB_HTRANS_NONSEQ 2'h2

// flag register 0
`define IFSB_B_CONV 13
`define IFSB_B_SER1_TX 12
`define IFSB_B_SER1_RX 11
`define IFSB_B_SSP1_EV 10
`define IFSB_B_SSP1_FLT 9
`define IFSB_B_TMR3 8
`define IFSB_B_TMR2 7
`define IFSB_B_CMP2 6
`define IFSB_B_CAP2 5
`define IFSB_B_TMR1 3
`define IFSB_B_CMP1 2
`define IFSB_B_CAP1 1
`define IFSB_B_EXT0 0
// flag register 1
`define IFSB_B_SER2_TX 15
`define IFSB_B_SER2_RX 14
`define IFSB_B_EXT2 13
`define IFSB_B_TMR5 12
`define IFSB_B_TMR4 11
`define IFSB_B_CMP4 10
`define IFSB_B_CMP3 9
`define IFSB_B_EXT1 4
`define IFSB_B_PINCHG 3
`define IFSB_B_COMPAR 2
`define IFSB_B_TW1_MST 1
`define IFSB_B_TW1_SLV 0
// flag register 2
`define IFSB_B_PARPORT 13
`define IFSB_B_CMP5 9
`define IFSB_B_CAP5 7
`define IFSB_B_CAP4 6
`define IFSB_B_CAP3 5
`define IFSB_B_SSP2_EV 1
`define IFSB_B_SSP2_FLT 0
// flag register 3
`define IFSB_B_CAL 14
`define IFSB_B_TW2_MST 2
`define IFSB_B_TW2_SLV 1

`endif

/* File: rtl/ifsb_flag_reg.v */
`timescale 1ns/1ps
`default_nettype none
`include "ifsb_regs.vh"

module ifsb_flag_reg #(
    parameter [15:0] IMPL = 16'hffff
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire wr_en,
    input wire clr_en,
    input wire [15:0] wdata,
    input wire [15:0] set,
    output wire [15:0] q
);
    reg [15:0] flag_q;
    reg [15:0] flag_d;

    always @* begin
        flag_d = flag_q;
        if (wr_en) begin
            flag_d = wdata;
        end else if (clr_en) begin
            flag_d = flag_q & ~wdata;
        end
        // hardware set beats a same-cycle software clear
        flag_d = (flag_d | set) & IMPL;
    end

    always @(posedge clk) begin
        if (rst) begin
            flag_q <= `IFSB_RST16;
        end else if (ce) begin
            flag_q <= flag_d;
        end
    end

    assign q = flag_q;
endmodule // ifsb_flag_reg

`default_nettype wire

/* File: rtl/ifsb_enable_reg.v */
`timescale 1ns/1ps
`default_nettype none
`include "ifsb_regs.vh"

module ifsb_enable_reg #(
    parameter [15:0] IMPL = 16'hffff
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire wr_en,
    input wire [15:0] wdata,
    output wire [15:0] q
);
    reg [15:0] en_q;

    always @(posedge clk) begin
        if (rst) begin
            en_q <= `IFSB_RST16;
        end else if (ce && wr_en) begin
            en_q <= wdata & IMPL;
        end
    end

    assign q = en_q;
endmodule // ifsb_enable_reg

`default_nettype wire

/* File: rtl/ifsb_flag_bank.v */
// Operation
// - an implemented flag reads one after its source requested or a write set it to one, else zero
// - register 0 bits 15-14 and 4, register 1 bits 8-5 read zero
// - implemented flags are software read/write and reset to zero
// - register 0 high byte: conversion, serial1 tx/rx, sync serial1 event/fault, timer 3
// - register 0 low byte: timer 2, compare 2, capture 2, timer 1, compare 1, capture 1, ext 0
// - register 1 high byte: serial2 tx/rx, ext 2, timers 5/4, compares 4/3
// - register 1 low bits: ext 1, pin change, comparator, two-wire1 master/slave
// - register 2: parallel port, compare 5, captures 5/4/3, sync serial2 event/fault
// - register 3: calendar at 14, two-wire2 master at 2, slave at 1
// - register 2 and 3 unimplemented bits read zero
// - bit positions follow vector order, external 0 at register 0 bit 0
// - each flag has an enable bit gating its interrupt, flag records regardless
`timescale 1ns/1ps
`default_nettype none
`include "ifsb_regs.vh"

module ifsb_flag_bank (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output wire [31:0] hrdata,
    output wire irq,
    input wire conversion_done_flag_set,
    input wire serial1_transmit_flag_set,
    input wire serial1_receive_flag_set,
    input wire sync_serial1_event_flag_set,
    input wire sync_serial1_fault_flag_set,
    input wire timer_three_flag_set,
    input wire timer_two_flag_set,
    input wire compare_two_flag_set,
    input wire capture_two_flag_set,
    input wire timer_one_flag_set,
    input wire compare_one_flag_set,
    input wire capture_one_flag_set,
    input wire ext_irq_zero_flag_set,
    input wire serial2_transmit_flag_set,
    input wire serial2_receive_flag_set,
    input wire ext_irq_two_flag_set,
    input wire timer_five_flag_set,
    input wire timer_four_flag_set,
    input wire compare_four_flag_set,
    input wire compare_three_flag_set,
    input wire ext_irq_one_flag_set,
    input wire pin_change_flag_set,
    input wire comparator_flag_set,
    input wire twowire1_master_flag_set,
    input wire twowire1_slave_flag_set,
    input wire parallel_port_flag_set,
    input wire compare_five_flag_set,
    input wire capture_five_flag_set,
    input wire capture_four_flag_set,
    input wire capture_three_flag_set,
    input wire sync_serial2_event_flag_set,
    input wire sync_serial2_fault_flag_set,
    input wire calendar_flag_set,
    input wire twowire2_master_flag_set,
    input wire twowire2_slave_flag_set
);
    reg [15:0] set0;
    reg [15:0] set1;
    reg [15:0] set2;
    reg [15:0] set3;
    wire [15:0] flag0;
    wire [15:0] flag1;
    wire [15:0] flag2;
    wire [15:0] flag3;
    wire [15:0] en0;
    wire [15:0] en1;
    wire [15:0] en2;
    wire [15:0] en3;
    reg [3:0] wr_flag;
    reg [3:0] clr_flag;
    reg [3:0] wr_en;
    reg [31:0] rd_val;
    reg [7:0] addr_q;
    reg wr_pend_q;
    reg rd_pend_q;
    reg hready_q;
    reg hresp_q;
    reg [31:0] hrdata_q;
    reg irq_q;
    wire acc;

    // source events placed in vector order
    always @* begin
        set0 = `IFSB_RST16;
        set1 = `IFSB_RST16;
        set2 = `IFSB_RST16;
        set3 = `IFSB_RST16;
        set0[`IFSB_B_CONV] = conversion_done_flag_set;
        set0[`IFSB_B_SER1_TX] = serial1_transmit_flag_set;
        set0[`IFSB_B_SER1_RX] = serial1_receive_flag_set;
        set0[`IFSB_B_SSP1_EV] = sync_serial1_event_flag_set;
        set0[`IFSB_B_SSP1_FLT] = sync_serial1_fault_flag_set;
        set0[`IFSB_B_TMR3] = timer_three_flag_set;
        set0[`IFSB_B_TMR2] = timer_two_flag_set;
        set0[`IFSB_B_CMP2] = compare_two_flag_set;
        set0[`IFSB_B_CAP2] = capture_two_flag_set;
        set0[`IFSB_B_TMR1] = timer_one_flag_set;
        set0[`IFSB_B_CMP1] = compare_one_flag_set;
        set0[`IFSB_B_CAP1] = capture_one_flag_set;
        set0[`IFSB_B_EXT0] = ext_irq_zero_flag_set;
        set1[`IFSB_B_SER2_TX] = serial2_transmit_flag_set;
        set1[`IFSB_B_SER2_RX] = serial2_receive_flag_set;
        set1[`IFSB_B_EXT2] = ext_irq_two_flag_set;
        set1[`IFSB_B_TMR5] = timer_five_flag_set;
        set1[`IFSB_B_TMR4] = timer_four_flag_set;
        set1[`IFSB_B_CMP4] = compare_four_flag_set;
        set1[`IFSB_B_CMP3] = compare_three_flag_set;
        set1[`IFSB_B_EXT1] = ext_irq_one_flag_set;
        set1[`IFSB_B_PINCHG] = pin_change_flag_set;
        set1[`IFSB_B_COMPAR] = comparator_flag_set;
        set1[`IFSB_B_TW1_MST] = twowire1_master_flag_set;
        set1[`IFSB_B_TW1_SLV] = twowire1_slave_flag_set;
        set2[`IFSB_B_PARPORT] = parallel_port_flag_set;
        set2[`IFSB_B_CMP5] = compare_five_flag_set;
        set2[`IFSB_B_CAP5] = capture_five_flag_set;
        set2[`IFSB_B_CAP4] = capture_four_flag_set;
        set2[`IFSB_B_CAP3] = capture_three_flag_set;
        set2[`IFSB_B_SSP2_EV] = sync_serial2_event_flag_set;
        set2[`IFSB_B_SSP2_FLT] = sync_serial2_fault_flag_set;
        set3[`IFSB_B_CAL] = calendar_flag_set;
        set3[`IFSB_B_TW2_MST] = twowire2_master_flag_set;
        set3[`IFSB_B_TW2_SLV] = twowire2_slave_flag_set;
    end

    assign acc = hsel && htrans[1] && hready;

    // write decode in the data phase
    always @* begin
        wr_flag = 4'h0;
        clr_flag = 4'h0;
        wr_en = 4'h0;
        if (wr_pend_q) begin
            if (addr_q == `IFSB_A_FLAG0) begin
                wr_flag[0] = 1'b1;
            end else if (addr_q == `IFSB_A_FLAG1) begin
                wr_flag[1] = 1'b1;
            end else if (addr_q == `IFSB_A_FLAG2) begin
                wr_flag[2] = 1'b1;
            end else if (addr_q == `IFSB_A_FLAG3) begin
                wr_flag[3] = 1'b1;
            end else if (addr_q == `IFSB_A_EN0) begin
                wr_en[0] = 1'b1;
            end else if (addr_q == `IFSB_A_EN1) begin
                wr_en[1] = 1'b1;
            end else if (addr_q == `IFSB_A_EN2) begin
                wr_en[2] = 1'b1;
            end else if (addr_q == `IFSB_A_EN3) begin
                wr_en[3] = 1'b1;
            end else if (addr_q == `IFSB_A_CLR0) begin
                clr_flag[0] = 1'b1;
            end else if (addr_q == `IFSB_A_CLR1) begin
                clr_flag[1] = 1'b1;
            end else if (addr_q == `IFSB_A_CLR2) begin
                clr_flag[2] = 1'b1;
            end else if (addr_q == `IFSB_A_CLR3) begin
                clr_flag[3] = 1'b1;
            end
        end
    end

    // read mux; clear aliases read the flags, unmapped reads zero
    always @* begin
        rd_val = `IFSB_RST32;
        if (addr_q == `IFSB_A_FLAG0 || addr_q == `IFSB_A_CLR0) begin
            rd_val = {16'h0000, flag0};
        end else if (addr_q == `IFSB_A_FLAG1 || addr_q == `IFSB_A_CLR1) begin
            rd_val = {16'h0000, flag1};
        end else if (addr_q == `IFSB_A_FLAG2 || addr_q == `IFSB_A_CLR2) begin
            rd_val = {16'h0000, flag2};
        end else if (addr_q == `IFSB_A_FLAG3 || addr_q == `IFSB_A_CLR3) begin
            rd_val = {16'h0000, flag3};
        end else if (addr_q == `IFSB_A_EN0) begin
            rd_val = {16'h0000, en0};
        end else if (addr_q == `IFSB_A_EN1) begin
            rd_val = {16'h0000, en1};
        end else if (addr_q == `IFSB_A_EN2) begin
            rd_val = {16'h0000, en2};
        end else if (addr_q == `IFSB_A_EN3) begin
            rd_val = {16'h0000, en3};
        end
    end

    ifsb_flag_reg #(.IMPL(`IFSB_IMPL0)) u_flag0 (
        .clk(clk), .rst(rst), .ce(ce), .wr_en(wr_flag[0]), .clr_en(clr_flag[0]),
        .wdata(hwdata[15:0]), .set(set0), .q(flag0)
    );
    ifsb_flag_reg #(.IMPL(`IFSB_IMPL1)) u_flag1 (
        .clk(clk), .rst(rst), .ce(ce), .wr_en(wr_flag[1]), .clr_en(clr_flag[1]),
        .wdata(hwdata[15:0]), .set(set1), .q(flag1)
    );
    ifsb_flag_reg #(.IMPL(`IFSB_IMPL2)) u_flag2 (
        .clk(clk), .rst(rst), .ce(ce), .wr_en(wr_flag[2]), .clr_en(clr_flag[2]),
        .wdata(hwdata[15:0]), .set(set2), .q(flag2)
    );
    ifsb_flag_reg #(.IMPL(`IFSB_IMPL3)) u_flag3 (
        .clk(clk), .rst(rst), .ce(ce), .wr_en(wr_flag[3]), .clr_en(clr_flag[3]),
        .wdata(hwdata[15:0]), .set(set3), .q(flag3)
    );

    ifsb_enable_reg #(.IMPL(`IFSB_IMPL0)) u_en0 (
        .clk(clk), .rst(rst), .ce(ce), .wr_en(wr_en[0]), .wdata(hwdata[15:0]), .q(en0)
    );
    ifsb_enable_reg #(.IMPL(`IFSB_IMPL1)) u_en1 (
        .clk(clk), .rst(rst), .ce(ce), .wr_en(wr_en[1]), .wdata(hwdata[15:0]), .q(en1)
    );
    ifsb_enable_reg #(.IMPL(`IFSB_IMPL2)) u_en2 (
        .clk(clk), .rst(rst), .ce(ce), .wr_en(wr_en[2]), .wdata(hwdata[15:0]), .q(en2)
    );
    ifsb_enable_reg #(.IMPL(`IFSB_IMPL3)) u_en3 (
        .clk(clk), .rst(rst), .ce(ce), .wr_en(wr_en[3]), .wdata(hwdata[15:0]), .q(en3)
    );

    // reads take one wait state so a write just before is visible
    always @(posedge clk) begin
        if (rst) begin
            addr_q <= `IFSB_RST8;
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            hready_q <= 1'b1;
            hresp_q <= 1'b0;
            hrdata_q <= `IFSB_RST32;
            irq_q <= 1'b0;
        end else if (ce) begin
            wr_pend_q <= acc && hwrite;
            rd_pend_q <= acc && !hwrite;
            if (acc) begin
                addr_q <= haddr[7:0];
            end
            if (acc && !hwrite) begin
                hready_q <= 1'b0;
            end else if (rd_pend_q) begin
                hrdata_q <= rd_val;
                hready_q <= 1'b1;
            end
            hresp_q <= 1'b0;
            irq_q <= |((flag0 & en0) | (flag1 & en1) | (flag2 & en2) | (flag3 & en3));
        end
    end

    assign hreadyout = hready_q;
    assign hresp = hresp_q;
    assign hrdata = hrdata_q;
    assign irq = irq_q;
endmodule // ifsb_flag_bank

`default_nettype wire

/* File: test/ifsb_flag_bank_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module ifsb_flag_bank_sva (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire rd_tk = hsel && htrans[1] && hready && ce && !hwrite;
    wire wr_tk = hsel && htrans[1] && hready && ce && hwrite;
    wire [63:0] impl_all = 64'h4006_22e3_fe1f_3fef;
    // every mapped alias shares the flag layout; above 0x2c nothing is implemented
    wire [15:0] impl_m = (haddr[7:0] < 8'h30) ? impl_all[{haddr[3:2], 4'h0} +: 16] : 16'h0;
    property p_rst_idle; $fell(rst) |-> hreadyout && hrdata == 32'h0 && !irq; endproperty
    property p_read_wait; rd_tk |=> !hreadyout ##1 hreadyout; endproperty
    property p_wait_cause; !hreadyout |-> $past(rd_tk); endproperty
    property p_write_fast; wr_tk |=> hreadyout; endproperty
    // irq can only drop three samples after a write was taken
    property p_irq_sticky; irq && !$past(wr_tk, 2) |=> irq; endproperty
    property p_data_hold; !$past(rd_tk, 2) && !$past(rst) |-> $stable(hrdata); endproperty
    property p_upper_zero; hrdata[31:16] == 16'h0; endproperty
    property p_resp_okay; hresp == 1'b0; endproperty
    property p_unimpl_zero; $past(rd_tk, 2) |-> (hrdata[15:0] & ~$past(impl_m, 2)) == 16'h0; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
    a_wait_cause: assert property (p_wait_cause) else $error("wait state without read");
    a_write_fast: assert property (p_write_fast) else $error("write stalled");
    a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped without write");
    a_data_hold: assert property (p_data_hold) else $error("read data changed between reads");
    a_upper_zero: assert property (p_upper_zero) else $error("upper read data not zero");
    a_resp_okay: assert property (p_resp_okay) else $error("error response given");
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit read one");
    c_read: cover property (rd_tk);
    c_irq: cover property ($rose(irq));
    c_b2b: cover property (wr_tk ##2 rd_tk);
endmodule // ifsb_flag_bank_sva
bind ifsb_flag_bank ifsb_flag_bank_sva chk_u (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq));
`default_nettype wire

/* File: test/ifsb_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ifsb_src_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [63:0] fire,
    output logic [63:0] ev
);
    // sources give requests as long as the command, launched one edge after the command
    always_ff @(posedge clk) begin
        if (rst) begin
            ev <= 64'h0;
        end else begin
            ev <= fire;
        end
    end
endmodule // ifsb_src_model
`default_nettype wire

/* File: test/ifsb_flag_bank_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ifsb_regs.vh"
module ifsb_flag_bank_test;
    localparam logic [63:0] IMPL_ALL = 64'h4006_22e3_fe1f_3fef;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [63:0] fire = 64'h0;
    wire [63:0] ev;
    wire hready;
    wire hresp;
    wire [31:0] hrdata;
    wire irq;
    logic [15:0] f_m [4];
    logic [15:0] e_m [4];
    int miscompares = 0;
    int cmp_count = 0;
    integer seed = 40;
    always #5 clk = ~clk;
    ifsb_src_model src_u (.clk(clk), .rst(rst), .fire(fire), .ev(ev));
    ifsb_flag_bank dut_u (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .irq(irq), .conversion_done_flag_set(ev[13]), .serial1_transmit_flag_set(ev[12]),
        .serial1_receive_flag_set(ev[11]), .sync_serial1_event_flag_set(ev[10]),
        .sync_serial1_fault_flag_set(ev[9]), .timer_three_flag_set(ev[8]), .timer_two_flag_set(ev[7]),
        .compare_two_flag_set(ev[6]), .capture_two_flag_set(ev[5]), .timer_one_flag_set(ev[3]),
        .compare_one_flag_set(ev[2]), .capture_one_flag_set(ev[1]), .ext_irq_zero_flag_set(ev[0]),
        .serial2_transmit_flag_set(ev[31]), .serial2_receive_flag_set(ev[30]), .ext_irq_two_flag_set(ev[29]),
        .timer_five_flag_set(ev[28]), .timer_four_flag_set(ev[27]), .compare_four_flag_set(ev[26]),
        .compare_three_flag_set(ev[25]), .ext_irq_one_flag_set(ev[20]), .pin_change_flag_set(ev[19]),
        .comparator_flag_set(ev[18]), .twowire1_master_flag_set(ev[17]), .twowire1_slave_flag_set(ev[16]),
        .parallel_port_flag_set(ev[45]), .compare_five_flag_set(ev[41]), .capture_five_flag_set(ev[39]),
        .capture_four_flag_set(ev[38]), .capture_three_flag_set(ev[37]), .sync_serial2_event_flag_set(ev[33]),
        .sync_serial2_fault_flag_set(ev[32]), .calendar_flag_set(ev[62]), .twowire2_master_flag_set(ev[50]),
        .twowire2_slave_flag_set(ev[49]));
    function automatic logic [15:0] impl(input int r);
        return IMPL_ALL[r * 16 +: 16];
    endfunction
    function automatic logic [31:0] rd_exp(input logic [7:0] a);
        if (a < 8'h10 || (a >= 8'h20 && a < 8'h30)) begin
            return {16'h0, f_m[a[3:2]]};
        end
        return (a < 8'h20) ? {16'h0, e_m[a[3:2]]} : 32'h0;
    endfunction
    task automatic finish_test();
        $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, hready, 1'b1);
            finish_test();
        end
    endtask
    // events ride along so they land on the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [63:0] e,
            output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= `IFSB_HTRANS_NONSEQ;
        hwrite <= w;
        fire <= e;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        fire <= 64'h0;
        wait_ready();
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [63:0] e);
        logic [31:0] q;
        bus(1'b1, a, d, e, q);
        if (a < 8'h10) f_m[a[3:2]] = d[15:0] & impl(a[3:2]);
        if (a >= 8'h10 && a < 8'h20) e_m[a[3:2]] = d[15:0] & impl(a[3:2]);
        if (a >= 8'h20 && a < 8'h30) f_m[a[3:2]] = f_m[a[3:2]] & ~d[15:0];
        // a same-edge request beats any clear
        for (int k = 0; k < 4; k++) f_m[k] = f_m[k] | (e[k * 16 +: 16] & impl(k));
    endtask
    task automatic rd(input logic [7:0] a);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 64'h0, q);
        check(q, rd_exp(a));
        check({31'h0, hresp}, 32'h0);
        check({31'h0, irq}, {31'h0, |({f_m[3], f_m[2], f_m[1], f_m[0]} & {e_m[3], e_m[2], e_m[1], e_m[0]})});
    endtask
    initial begin
        logic [7:0] a;
        logic [31:0] d;
        logic [63:0] e;
        for (int k = 0; k < 4; k++) begin
            f_m[k] = 16'h0;
            e_m[k] = 16'h0;
        end
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 13; k++) rd(8'(k * 4));
        $display("test reset_values done");
        for (int r = 0; r < 4; r++) begin
            wr(8'(r * 4), 32'hffff_ffff, 64'h0);
            wr(8'(16 + r * 4), 32'hffff_ffff, 64'h0);
            rd(8'(r * 4));
            rd(8'(16 + r * 4));
        end
        wr(8'h30, 32'hffff_ffff, 64'h0);
        rd(8'h30);
        $display("test access_holes done");
        for (int i = 0; i < 64; i++) begin
            if (IMPL_ALL[i]) begin
                wr(8'(32 + (i / 16) * 4), 32'h0000_ffff, 64'h1 << i);
                rd(8'(32 + (i / 16) * 4));
            end
        end
        $display("test source_walk done");
        for (int n = 0; n < 400; n++) begin
            a = 8'(($unsigned($random(seed)) % 13) * 4);
            d = $random(seed);
            e = {$random(seed), $random(seed)} & {$random(seed), $random(seed)};
            if ($random(seed) & 1) begin
                wr(a, d, e);
            end else begin
                rd(a);
            end
        end
        $display("test random_traffic done");
        // reset in mid-run with flags and enables left set
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            f_m[k] = 16'h0;
            e_m[k] = 16'h0;
        end
        for (int k = 0; k < 13; k++) rd(8'(k * 4));
        $display("test mid_reset done");
        // idle edges first so irq settles before the freeze
        repeat (2) @(posedge clk);
        ce <= 1'b0;
        fire <= '1;
        repeat (3) @(posedge clk);
        fire <= 64'h0;
        @(posedge clk);
        ce <= 1'b1;
        for (int r = 0; r < 4; r++) rd(8'(r * 4));
        $display("test clock_enable done");
        finish_test();
    end
endmodule // ifsb_flag_bank_test
`default_nettype wire
